//--- verilog/power_seq_consts.svh
// Timing constants for the three-rail power sequencer.
// Assumes a 10 MHz ref_clk; times are in microseconds.
`ifndef POWER_SEQ_CONSTS_SVH
`define POWER_SEQ_CONSTS_SVH

`define CLK_FREQ_MHZ      10
`define PWR_GOOD_DLY_US   12000
`define UP_SEQ_DLY_US     750
`define DOWN_SEQ_DLY_US   800
// Microseconds to whole clock cycles; exact at a whole-MHz clock
`define US_TO_CYC(us)     (((us) * `CLK_FREQ_MHZ))
`define PWR_GOOD_DLY_CYC  `US_TO_CYC(`PWR_GOOD_DLY_US)
`define UP_SEQ_DLY_CYC    `US_TO_CYC(`UP_SEQ_DLY_US)
`define DOWN_SEQ_DLY_CYC  `US_TO_CYC(`DOWN_SEQ_DLY_US)
`define SYNC_STAGES       2

`endif

//--- verilog/power_seq_pkg.sv
// Types for the three-rail power sequencer.
// Assumes nothing beyond the consts header for its numbers.
package power_seq_pkg;

   // Comparator flags from the analog front end
   typedef struct packed {
      logic primaryOk;
      logic ioOk;
      logic coreOk;
      logic feedbackOk;
   } sense_t;

   // Board control pins
   typedef struct packed {
      logic primaryGateEnable;
      logic sequenceEnable;
      logic voltageStart;
   } ctrl_t;

   // Secondary rail sequence states
   typedef enum logic [2:0] {
      SEQ_OFF,
      SEQ_CORE_UP,
      SEQ_BOTH_ON,
      SEQ_CORE_DOWN
   } seq_state_t;

endpackage : power_seq_pkg

//--- verilog/three_rail_power_sequencer.sv
// Sequencer for primary, I/O and core supply rails: power-good delay,
// primary gate pass-through, core-first-up / core-last-down ordering.
// Assumes comparator flags and control pins arrive asynchronously and
// ref_clk runs free; rst_n is derived from the primary lockout.
// Every output is registered; each input sees two flops of sync latency.
//
// What this block does
// R1: Power good rises only after the primary sense has stayed valid for the full delay.
// R2: The primary gate follows its enable input, gated by primary sense, after the two sync flops and its output flop.
// R3: I/O and core rails are neither watched nor sequenced until primary is good.
// R4: The I/O gate is never on while the I/O sense is below its lockout level.
// R5: The core gate is never on while the core sense is below its lockout level.
// R6: In time mode a rising sequence enable switches the core gate on.
// R7: In time mode a falling sequence enable switches the I/O gate off first.
// R8: In voltage mode the voltage start input switches the core gate on.
// R9: In voltage mode the I/O gate stays off until core feedback reaches threshold.
// R10: Core comes on before I/O at power-up and goes off after I/O at power-down.
// R11: Sequence enable is edge-triggered and I/O follows core after the up delay.
// R12: In voltage mode the I/O gate comes on once feedback exceeds the reference.
// R13: After a falling voltage start turns I/O off, core turns off a down delay later.
// R14: Losing the primary supply turns all three gates off at once.
// R15: All asynchronous inputs are synchronised before edge detection and timing.
`timescale 1ns/1ps

`include "power_seq_consts.svh"

module three_rail_power_sequencer
   import power_seq_pkg::*;
#(
   parameter int PWR_GOOD_CYC = `PWR_GOOD_DLY_CYC,
   parameter int UP_CYC       = `UP_SEQ_DLY_CYC,
   parameter int DOWN_CYC     = `DOWN_SEQ_DLY_CYC
) (
   input  wire logic   ref_clk,
   input  wire logic   rst_n,
   input  wire sense_t senseIn,
   input  wire ctrl_t  ctrlIn,
   output logic        powerGood,
   output logic        primaryGate,
   output logic        ioGate,
   output logic        coreGate
);

   // Timer and counter width; wide enough for any delay an int can carry
   localparam int CW = 32;

   // Elaboration checks: a zero delay would skip the power-good wait, or wrap len - 1 and stall a gate step
   if (PWR_GOOD_CYC < 1) begin : g_bad_good
      $error("three_rail_power_sequencer: PWR_GOOD_CYC must be at least one");
   end
   if (UP_CYC < 1) begin : g_bad_up
      $error("three_rail_power_sequencer: UP_CYC must be at least one");
   end
   if (DOWN_CYC < 1) begin : g_bad_down
      $error("three_rail_power_sequencer: DOWN_CYC must be at least one");
   end
   // Only a two-flop synchroniser is built below
   if (`SYNC_STAGES != 2) begin : g_bad_sync
      $error("three_rail_power_sequencer: only two synchroniser stages are built");
   end

   // Rising edge of a synchronised level against its one-cycle-old copy
   function automatic logic rose_now(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction : rose_now

   // Falling edge of a synchronised level against its one-cycle-old copy
   function automatic logic fell_now(input logic cur, input logic prev);
      return ~cur & prev;
   endfunction : fell_now

   // Timer started at zero has run len - 1 cycles when done; the step it triggers lands
   // on the next edge, so the gate moves exactly len edges after the start
   function automatic logic timer_done(input logic [CW-1:0] cnt, input int len);
      return cnt >= CW'(len - 1);
   endfunction : timer_done

   // Two-stage synchronisers kept as the package bundles; the first stage
   // feeds only the second, so nothing decodes a possibly metastable bit
   sense_t senseA_q;
   sense_t senseB_q;
   ctrl_t  ctrlA_q;
   ctrl_t  ctrlB_q;

   // Comparator flags
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         senseA_q <= '0;
         senseB_q <= '0;
      end else begin
         senseA_q <= senseIn;    // R15
         senseB_q <= senseA_q;   // R15
      end
   end

   // Board control pins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlA_q <= '0;
         ctrlB_q <= '0;
      end else begin
         ctrlA_q <= ctrlIn;      // R15
         ctrlB_q <= ctrlA_q;     // R15
      end
   end

   // Named views of the synchronised inputs
   wire primaryOk     = senseB_q.primaryOk;
   wire ioOk          = senseB_q.ioOk;
   wire coreOk        = senseB_q.coreOk;
   wire feedbackOk    = senseB_q.feedbackOk;
   wire primaryGateEn = ctrlB_q.primaryGateEnable;
   wire seqEnable     = ctrlB_q.sequenceEnable;
   wire voltStart     = ctrlB_q.voltageStart;

   // Previous values for edge detection on synchronised pins
   logic seqEnPrev_q;
   logic voltPrev_q;

   // Sequence enable one cycle back; a pin held high through reset shows
   // an edge here, which is refused because primary is not yet good
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seqEnPrev_q <= 1'b0;
      end else begin
         seqEnPrev_q <= seqEnable;
      end
   end

   // Voltage start one cycle back
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         voltPrev_q <= 1'b0;
      end else begin
         voltPrev_q <= voltStart;
      end
   end

   // Start and stop events; the sequence pins act on edges, never on levels
   wire seqRise  = rose_now(seqEnable, seqEnPrev_q);   // R11
   wire seqFall  = fell_now(seqEnable, seqEnPrev_q);   // R11
   wire voltRise = rose_now(voltStart, voltPrev_q);
   wire voltFall = fell_now(voltStart, voltPrev_q);

   // Power-good qualification: the count restarts whenever primary drops
   logic [CW-1:0] goodCnt_q;
   logic          good_q;
   wire           goodReached = (goodCnt_q >= CW'(PWR_GOOD_CYC));

   // Qualification counter, held once the full delay has run
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         goodCnt_q <= '0;
      end else if (!primaryOk) begin
         goodCnt_q <= '0;                 // R1
      end else if (!goodReached) begin
         goodCnt_q <= goodCnt_q + 1'b1;
      end
   end

   // Good flag: set after the full delay, cleared with primary at once
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         good_q <= 1'b0;
      end else if (!primaryOk) begin
         good_q <= 1'b0;                  // R14
      end else if (goodReached) begin
         good_q <= 1'b1;                  // R1
      end
   end

   // Secondary rails sequenced only with primary good (reset-style gate)
   wire active = good_q & primaryOk; // R3 R14

   // Sequence state and shared delay timer
   seq_state_t    state_q;
   seq_state_t    state_d;
   logic [CW-1:0] tmr_q;
   logic [CW-1:0] tmr_d;
   logic          voltMode_q;
   logic          voltMode_d;

   // Timer expiry used by both up and down paths
   wire upDone   = timer_done(tmr_q, UP_CYC);
   wire downDone = timer_done(tmr_q, DOWN_CYC);

   // Rail loss: I/O loss walks a down delay, core loss drops both
   wire startUp   = seqRise | voltRise;
   wire startDown = seqFall | voltFall | ~ioOk;

   // Next-state logic. OFF waits for a start edge; CORE_UP holds the core
   // gate while the timer or the feedback comparator clears the I/O step;
   // BOTH_ON waits for a stop edge or I/O loss; CORE_DOWN keeps the core on
   // for the down delay. Core or primary loss drops straight to OFF, since
   // a collapsed rail must not be held up by the down delay.
   always_comb begin
      state_d    = state_q;
      tmr_d      = tmr_q;
      voltMode_d = voltMode_q;
      if (!active || !coreOk) begin
         state_d = SEQ_OFF;                         // R5 R14
         tmr_d   = '0;
      end else begin
         case (state_q)
            SEQ_OFF: begin
               if (startUp) begin
                  state_d    = SEQ_CORE_UP;           // R6 R8 R10
                  voltMode_d = voltRise & ~seqRise;
                  tmr_d      = '0;
               end
            end
            SEQ_CORE_UP: begin
               // Timer holds once expired, so a long wait on the I/O rail cannot wrap it
               if (!upDone) begin
                  tmr_d = tmr_q + 1'b1;
               end
               if (seqFall || voltFall) begin
                  state_d = SEQ_CORE_DOWN;
                  tmr_d   = '0;
               end else if (voltMode_q ? feedbackOk : upDone) begin
                  if (ioOk) begin
                     state_d = SEQ_BOTH_ON;          // R9 R11 R12
                  end
               end
            end
            SEQ_BOTH_ON: begin
               if (startDown) begin
                  state_d = SEQ_CORE_DOWN;           // R7 R10
                  tmr_d   = '0;
               end
            end
            SEQ_CORE_DOWN: begin
               tmr_d = tmr_q + 1'b1;
               if (downDone) begin
                  state_d = SEQ_OFF;                 // R13
               end
            end
            default: begin
               state_d = SEQ_OFF;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SEQ_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // Shared delay timer for the up and down steps
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_d;
      end
   end

   // Mode latched at the start edge: comparator or timer clears the I/O step
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         voltMode_q <= 1'b0;
      end else begin
         voltMode_q <= voltMode_d;
      end
   end

   // Gate decode from next state so outputs land in the same edge as the state
   wire coreOnD = (state_d != SEQ_OFF);               // R10
   wire ioOnD   = (state_d == SEQ_BOTH_ON) & ioOk;    // R4

   // Power good tracks the qualified flag and falls with primary at once
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         powerGood <= 1'b0;
      end else begin
         powerGood <= good_q & primaryOk;               // R1 R14
      end
   end

   // Primary gate passes its enable after the sync latency plus this output flop
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         primaryGate <= 1'b0;
      end else begin
         primaryGate <= primaryGateEn & primaryOk;      // R2 R14
      end
   end

   // I/O gate from the next-state decode, so it moves on the state's own edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ioGate <= 1'b0;
      end else begin
         ioGate <= ioOnD;                               // R4 R7
      end
   end

   // Core gate from the next-state decode; the flop keeps it glitch-free
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         coreGate <= 1'b0;
      end else begin
         coreGate <= coreOnD;                           // R5 R6 R8
      end
   end

endmodule : three_rail_power_sequencer

//--- verification/core_rail_model.sv
// Board model of the core FET and its feedback comparator.
// Assumes the core gate is a level sampled on ref_clk.
`timescale 1ns/1ps
module core_rail_model #(
   parameter int RAMP_CYC = 8
) (
   input  wire logic ref_clk,
   input  wire logic coreGate,
   output logic      feedbackOk
);
   int ramp_q = 0;
   // Rail ramps slowly while on but collapses at once, so a late drop is seen
   always_ff @(posedge ref_clk) begin
      ramp_q <= coreGate ? (ramp_q < RAMP_CYC ? ramp_q + 1 : ramp_q) : 0;
   end
   assign feedbackOk = (ramp_q >= RAMP_CYC);
endmodule : core_rail_model

//--- verification/power_seq_checker.sv
// Port assertions for the three-rail sequencer.
// Assumes one clock and the async active-low reset.
`timescale 1ns/1ps
`include "power_seq_consts.svh"
module power_seq_checker
   import power_seq_pkg::*;
#(
   parameter int PWR_GOOD_CYC = `PWR_GOOD_DLY_CYC
) (
   input wire logic   ref_clk,
   input wire logic   rst_n,
   input wire sense_t senseIn,
   input wire ctrl_t  ctrlIn,
   input wire logic   powerGood,
   input wire logic   primaryGate,
   input wire logic   ioGate,
   input wire logic   coreGate
);
   int okRun_q;
   // Length of the unbroken primary-valid stretch
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n) okRun_q <= 0;
      else okRun_q <= senseIn.primaryOk ? okRun_q + 1 : 0;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_pg; $rose(powerGood) |-> okRun_q >= PWR_GOOD_CYC; endproperty
   a_pg: assert property (p_pg) else $error("power good early");
   property p_pri; (ctrlIn.primaryGateEnable && senseIn.primaryOk)[*4] |-> primaryGate; endproperty
   a_pri: assert property (p_pri) else $error("primary gate late");
   property p_wait; $rose(coreGate) |-> powerGood; endproperty
   a_wait: assert property (p_wait) else $error("core before power good");
   property p_io; (!senseIn.ioOk)[*4] |-> !ioGate; endproperty
   a_io: assert property (p_io) else $error("io gate without io rail");
   property p_core; (!senseIn.coreOk)[*4] |-> !coreGate && !ioGate; endproperty
   a_core: assert property (p_core) else $error("gates without core rail");
   property p_up; $rose(ioGate) |-> coreGate && $past(coreGate, 3); endproperty
   a_up: assert property (p_up) else $error("io before core");
   property p_dn; $fell(ioGate) && coreGate |=> coreGate[*3]; endproperty
   a_dn: assert property (p_dn) else $error("core off too soon");
   property p_lost; (!senseIn.primaryOk)[*4] |-> !(powerGood | primaryGate | ioGate | coreGate); endproperty
   a_lost: assert property (p_lost) else $error("gates on without primary");
endmodule : power_seq_checker
bind three_rail_power_sequencer power_seq_checker #(.PWR_GOOD_CYC(PWR_GOOD_CYC)) u_chk (
   .ref_clk, .rst_n, .senseIn, .ctrlIn, .powerGood, .primaryGate, .ioGate, .coreGate);

//--- verification/tb.sv
// Self-checking bench for the three-rail sequencer.
// Assumes shortened delays and the core rail model on the far side.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
   import power_seq_pkg::*;
   localparam int PG = 20;
   localparam int UP = 5;
   localparam int DN = 6;
   localparam int FB = 8;
   logic ref_clk = 0, rst_n = 0, pOk = 0, ioOk = 1, coreOk = 1, gEn = 0, seqEn = 0, vStart = 0;
   logic fbOk, powerGood, primaryGate, ioGate, coreGate;
   int n_errors = 0, checks = 0, n;
   sense_t senseIn;
   ctrl_t ctrlIn;
   assign senseIn = '{pOk, ioOk, coreOk, fbOk};
   assign ctrlIn = '{gEn, seqEn, vStart};
   always #50 ref_clk = ~ref_clk;
   three_rail_power_sequencer #(.PWR_GOOD_CYC(PG), .UP_CYC(UP), .DOWN_CYC(DN)) dut (
      .ref_clk, .rst_n, .senseIn, .ctrlIn, .powerGood, .primaryGate, .ioGate, .coreGate);
   core_rail_model #(.RAMP_CYC(FB)) model (.ref_clk, .coreGate, .feedbackOk(fbOk));
   task cyc(input int k); repeat (k) @(negedge ref_clk); endtask : cyc
   // Bounded wait on a gate or power good; k returns the cycles it took
   task waitg(input int sel, input logic v, output int k);
      k = 0;
      while (k < 60 && (sel == 0 ? coreGate : sel == 1 ? ioGate : powerGood) !== v) begin
         @(negedge ref_clk);
         k++;
      end
   endtask : waitg
   task t_powerup;
      seqEn = 1; pOk = 1; cyc(PG / 2);
      `CHK(powerGood, 1'b0)
      `CHK(primaryGate, 1'b0)
      waitg(2, 1'b1, n); `CHK(n >= PG / 2 && n < 60, 1'b1)
      cyc(8); `CHK(coreGate, 1'b0)
      gEn = 1; cyc(4); `CHK(primaryGate, 1'b1)
      seqEn = 0; cyc(4);
   endtask : t_powerup
   task t_time;
      seqEn = 1; waitg(0, 1'b1, n); `CHK(coreGate, 1'b1)
      `CHK(ioGate, 1'b0)
      waitg(1, 1'b1, n); `CHK(n >= UP - 1 && n <= UP + 1, 1'b1)
      seqEn = 0; waitg(1, 1'b0, n); `CHK(coreGate, 1'b1)
      waitg(0, 1'b0, n); `CHK(n >= DN - 1 && n <= DN + 1, 1'b1)
   endtask : t_time
   task t_volt;
      vStart = 1; waitg(0, 1'b1, n); `CHK(coreGate, 1'b1)
      waitg(1, 1'b1, n); `CHK(fbOk, 1'b1)
      `CHK(n >= FB && n < 60, 1'b1)
      vStart = 0; waitg(1, 1'b0, n); `CHK(coreGate, 1'b1)
      waitg(0, 1'b0, n); `CHK(n >= DN - 1 && n <= DN + 1, 1'b1)
   endtask : t_volt
   task t_faults;
      ioOk = 0; seqEn = 1; cyc(UP + 8); `CHK(ioGate, 1'b0)
      seqEn = 0; ioOk = 1; cyc(DN + 4); seqEn = 1; waitg(1, 1'b1, n);
      `CHK({coreGate, ioGate}, 2'b11)
      coreOk = 0; cyc(4); `CHK({coreGate, ioGate}, 2'b00)
      coreOk = 1; seqEn = 0; cyc(DN + 4); seqEn = 1; waitg(1, 1'b1, n);
      `CHK({primaryGate, powerGood, coreGate, ioGate}, 4'hF)
      pOk = 0; cyc(4); `CHK({primaryGate, ioGate, coreGate, powerGood}, 4'h0)
   endtask : t_faults
   task tally_and_finish;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   // Main sequence and a watchdog far beyond the roughly 140 cycles needed
   initial begin
      cyc(2); rst_n = 1; cyc(2);
      t_powerup; t_time; t_volt; t_faults;
      tally_and_finish;
   end
   initial begin
      #200000; n_errors++; tally_and_finish;
   end
endmodule : tb
